/* File: hdl/pee_pkg.sv */
`default_nettype none
package pee_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int T_ACC_NS = 150; // Read access allowance
    localparam int T_WP_NS = 100; // Write enable low width
    localparam int T_PROG_MS = 3; // Longest programming cycle
    localparam int T_ERASE_MS = 10; // Chip erase pulse
    localparam int T_WIN_US = 100; // Byte load window kept by host
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_CYC = (T_PROG_MS * 1000000) / CLK_NS;
    localparam int ERASE_CYC = (T_ERASE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int WIN_CYC = (T_WIN_US * 1000) / CLK_NS;
    localparam int CNT_W = 20;
    // ------------------------------------------------------------
    // Device geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int PAGE_LSB = 6;
    localparam int PAGE_BYTES = 64;
    localparam int DQ_POLL = 7;
    localparam int DQ_TOG = 6;
    localparam int DQ_PLT = 5;
    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_ADDR_LSB = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_ERR = 2;
    localparam int STAT_TMO = 3;
    localparam int STAT_RB = 4;
    localparam int STAT_PLT = 5;
    localparam int STAT_WIN = 6;
    localparam int STAT_RDATA_LSB = 8;
    localparam logic [31:0] CMD_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_POLL = 2'h2,
        OP_ERASE = 2'h3
    } pee_op_t;

    // Page number of a byte address
    function automatic logic [ADDR_W-PAGE_LSB-1:0] pee_page(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:PAGE_LSB];
    endfunction
endpackage
`default_nettype wire

/* File: hdl/pee_axil_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module pee_axil_regs import pee_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Controller side
    output logic cmd_valid,
    output logic [31:0] cmd_word,
    output logic page_lock,
    input wire logic [31:0] status
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic lock;
        logic cmd_valid;
        logic [31:0] cmd;
    } pee_rs_t;

    pee_rs_t q, d;

    // Byte-lane merge honouring write strobes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Ready terms: one write and one read in flight
    assign s_awready = !q.aw_got && !q.bvalid;
    assign s_wready = !q.w_got && !q.bvalid;
    assign s_arready = !q.rvalid;
    assign s_bvalid = q.bvalid;
    assign s_bresp = q.bresp;
    assign s_rvalid = q.rvalid;
    assign s_rdata = q.rdata;
    assign s_rresp = q.rresp;
    assign cmd_valid = q.cmd_valid;
    assign cmd_word = q.cmd;
    assign page_lock = q.lock;

    // Next state: address and data may arrive in either order
    always_comb begin
        d = q;
        d.cmd_valid = 1'b0;
        if (s_awvalid && s_awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            d.w_got = 1'b1;
            d.wdata = s_wdata;
            d.wstrb = s_wstrb;
        end
        if (q.bvalid && s_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            case (q.awaddr)
                REG_CMD: begin
                    d.cmd = merge(q.cmd, q.wdata, q.wstrb);
                    d.cmd_valid = 1'b1;
                end
                REG_CTRL: begin
                    if (q.wstrb[0]) begin
                        d.lock = q.wdata[0];
                    end
                end
                REG_STAT: d.bresp = RESP_OKAY; // Read only, write ignored
                default: d.bresp = RESP_SLVERR;
            endcase
        end
        if (q.rvalid && s_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            case (s_araddr)
                REG_CMD: d.rdata = q.cmd;
                REG_CTRL: d.rdata = {31'h0000_0000, q.lock};
                REG_STAT: d.rdata = status;
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.cmd <= CMD_RST;
        end else begin
            q <= d;
        end
    end
endmodule // pee_axil_regs
`default_nettype wire

/* File: hdl/pee_ctrl.sv */
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Write starts with write and chip enable low, output enable held high.
// - All loads of one page share address bits 6 to 10; the controller refuses a cross-page load only while page_lock is set.
// - Next load must follow within the load window, else programming starts.
// - Chip erase: chip enable low, high voltage on output enable, 10 ms write pulse.
// - Protection sequences change address bits 6 to 10 between loads.
// - Protection uses fixed bytes at three, or six, locations in a page write.
module pee_ctrl import pee_pkg::*; #(
    parameter int PROG_TMO = PROG_CYC,
    parameter int ERASE_LEN = ERASE_CYC,
    parameter int LOAD_WIN = WIN_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Memory device pins
    output logic [ADDR_W-1:0] address_pins,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic [DATA_W-1:0] data_pins,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic erase_hv_en,
    input wire logic ready_busy_n
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_RD_SET = 7'h02,
        S_RD_ACC = 7'h04,
        S_WR_SET = 7'h08,
        S_WR_LOW = 7'h10,
        S_WR_HOLD = 7'h20,
        S_GAP = 7'h40
    } pee_st_t;

    typedef struct packed {
        pee_st_t st;
        pee_op_t op;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] tmo_cnt;
        logic [CNT_W-1:0] win_cnt;
        logic win_open;
        logic [6:0] loads;
        logic [ADDR_W-PAGE_LSB-1:0] last_page;
        logic [DATA_W-1:0] rdata;
        logic prev_tog;
        logic first;
        logic done;
        logic err;
        logic tmo;
        logic plt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic doe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic hv;
    } pee_cs_t;

    pee_cs_t q, d;
    logic cmd_valid;
    logic [31:0] cmd_word;
    logic page_lock;
    logic [31:0] status;
    pee_op_t c_op;
    logic [ADDR_W-1:0] c_addr;
    logic page_bad;

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    pee_axil_regs u_regs (
        .clk(clk), .rst_n(rst_n),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .page_lock(page_lock), .status(status)
    );

    // Command decode and status word
    assign c_op = pee_op_t'(cmd_word[CMD_OP_LSB +: 2]);
    assign c_addr = cmd_word[CMD_ADDR_LSB +: ADDR_W];
    // Lock off lets protection sequences cross pages
    assign page_bad = page_lock && q.win_open && (pee_page(c_addr) != q.last_page);
    assign status = {16'h0000, q.rdata, 1'b0, q.win_open, q.plt, ready_busy_n,
                     q.tmo, q.err, q.done, (q.st != S_IDLE)};

    // Pins straight from flops
    assign address_pins = q.addr;
    assign data_out = q.dout;
    assign data_oe_n = q.doe_n;
    assign ce_n = q.ce_n;
    assign oe_n = q.oe_n;
    assign we_n = q.we_n;
    assign erase_hv_en = q.hv;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // Load window runs down on its own; expiry closes the page
        if (q.win_open) begin
            if (q.win_cnt == '0) begin
                d.win_open = 1'b0;
                d.loads = 7'h00;
            end else begin
                d.win_cnt = q.win_cnt - 20'h00001;
            end
        end
        case (q.st)
            S_IDLE: begin
                if (cmd_valid) begin
                    d.done = 1'b0;
                    d.err = 1'b0;
                    d.tmo = 1'b0;
                    d.op = c_op;
                    d.addr = c_addr;
                    d.dout = cmd_word[CMD_DATA_LSB +: DATA_W];
                    if (c_op == OP_READ || c_op == OP_POLL) begin
                        d.ce_n = 1'b0;
                        d.first = 1'b1;
                        d.tmo_cnt = CNT_W'(PROG_TMO);
                        d.st = S_RD_SET;
                    end else if (!ready_busy_n || page_bad ||
                                 (c_op == OP_WRITE && q.loads == 7'(PAGE_BYTES))) begin
                        d.err = 1'b1;
                    end else begin
                        d.ce_n = 1'b0;
                        d.oe_n = 1'b1;
                        d.doe_n = (c_op != OP_WRITE);
                        d.hv = (c_op == OP_ERASE);
                        d.st = S_WR_SET;
                    end
                end
            end
            S_RD_SET: begin
                d.oe_n = 1'b0;
                d.cnt = CNT_W'(ACC_CYC - 1);
                d.st = S_RD_ACC;
            end
            S_RD_ACC: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 20'h00001;
                end else begin
                    // Raise both strobes so the next read counts as a new one
                    d.ce_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.rdata = data_pins;
                    d.plt = data_pins[DQ_PLT];
                    d.prev_tog = data_pins[DQ_TOG];
                    d.first = 1'b0;
                    if (q.op == OP_READ) begin
                        d.done = 1'b1;
                        d.st = S_IDLE;
                    end else if (!q.first && data_pins[DQ_TOG] == q.prev_tog) begin
                        d.done = 1'b1;
                        d.st = S_IDLE;
                    end else begin
                        d.st = S_GAP;
                    end
                end
                if (q.op == OP_POLL) begin
                    d.tmo_cnt = q.tmo_cnt - 20'h00001;
                end
            end
            S_GAP: begin
                d.ce_n = 1'b0;
                d.oe_n = 1'b0;
                d.cnt = CNT_W'(ACC_CYC - 1);
                d.tmo_cnt = q.tmo_cnt - 20'h00001;
                d.st = S_RD_ACC;
            end
            S_WR_SET: begin
                // Address already stable, so the later falling edge is this one
                d.we_n = 1'b0;
                d.cnt = (q.op == OP_ERASE) ? CNT_W'(ERASE_LEN - 1) : CNT_W'(WP_CYC - 1);
                d.st = S_WR_LOW;
            end
            S_WR_LOW: begin
                if (q.cnt != '0) begin
                    d.cnt = q.cnt - 20'h00001;
                end else begin
                    d.we_n = 1'b1;
                    d.st = S_WR_HOLD;
                end
            end
            S_WR_HOLD: begin
                // Data held one cycle past the rising edge of write enable
                d.ce_n = 1'b1;
                d.doe_n = 1'b1;
                d.hv = 1'b0;
                d.done = 1'b1;
                d.st = S_IDLE;
                if (q.op == OP_WRITE) begin
                    d.win_open = 1'b1;
                    d.win_cnt = CNT_W'(LOAD_WIN);
                    // Counts on from the expiry above, so a page opened as the
                    // old window lapses starts again at one load
                    d.loads = d.loads + 7'h01;
                    d.last_page = pee_page(q.addr);
                end
            end
            default: d.st = S_IDLE;
        endcase
        // Poll gives up after the longest programming time
        if ((q.st == S_RD_ACC || q.st == S_GAP) && q.op == OP_POLL && q.tmo_cnt == '0) begin
            d.tmo = 1'b1;
            d.err = 1'b1;
            d.ce_n = 1'b1;
            d.oe_n = 1'b1;
            d.done = 1'b0;
            d.st = S_IDLE;
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= S_IDLE;
            q.op <= OP_READ;
            q.doe_n <= 1'b1;
            q.ce_n <= 1'b1;
            q.oe_n <= 1'b1;
            q.we_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_OE_HIGH_IN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        !we_n |-> oe_n && !ce_n) else $error("write enable low without ce low and oe high");
    AST_NO_FIGHT: assert property (@(posedge clk) disable iff (!rst_n)
        !oe_n |-> data_oe_n && we_n && !ce_n) else $error("host drives during a read");
    AST_WE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(we_n) && !erase_hv_en |-> !we_n [*5] ##1 we_n) else $error("write pulse width");
    AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(we_n) && !erase_hv_en |-> !data_oe_n && $stable(data_out) && $stable(address_pins))
        else $error("data not held at write enable rise");
    AST_ERASE_HV: assert property (@(posedge clk) disable iff (!rst_n)
        erase_hv_en |-> oe_n && data_oe_n && !ce_n) else $error("bad erase pin state");
    AST_RB_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_IDLE && cmd_valid && !ready_busy_n && c_op == OP_WRITE |=> q.err ##1 we_n)
        else $error("write issued while device busy");
    AST_PAGE_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_IDLE && cmd_valid && c_op == OP_WRITE && page_bad |=> q.st == S_IDLE && q.err)
        else $error("cross-page load not refused");
    AST_TOGGLE_DONE: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_RD_ACC && q.cnt == '0 && q.op == OP_POLL && !q.first && q.tmo_cnt != '0
        && data_pins[DQ_TOG] == q.prev_tog |=> q.done && q.st == S_IDLE)
        else $error("stable toggle not seen as done");
    AST_WIN_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_WR_HOLD && q.op == OP_WRITE |=> q.win_open && q.win_cnt == CNT_W'(LOAD_WIN))
        else $error("load window not started");
    AST_POLL_TMO: assert property (@(posedge clk) disable iff (!rst_n)
        q.st == S_GAP && q.op == OP_POLL && q.tmo_cnt == '0 |=> q.tmo && ce_n && oe_n)
        else $error("poll timeout not taken");
endmodule // pee_ctrl
`default_nettype wire

/* File: tb/pee_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pee_dev_model import pee_pkg::*; #(
    parameter int WIN_LEN = 40,
    parameter int PROG_LEN = 100,
    // Protected state; the entry and exit sequences are not modelled
    parameter bit PROTECT = 1'b0
) (
    // Timing reference
    input wire logic clk,
    // Device pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic hv,
    output logic [DATA_W-1:0] dq_q,
    output logic [DATA_W-1:0] dq_en,
    output logic rb_low
);
    logic [7:0] mem [2048];
    logic [7:0] pg [64];
    logic [63:0] pg_v = 64'h0;
    logic [10:0] a_q;
    logic [10:0] last_a;
    logic [7:0] last_d = 8'h00;
    logic wr_q = 1'h0;
    logic rd_q = 1'h0;
    logic tog = 1'h0;
    int win = 0;
    int busy = 0;
    wire logic wr = !ce_n && !we_n && oe_n;
    wire logic rd = !ce_n && !oe_n && we_n;
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // ------
    // Strobe edges, load window, programming
    // ------
    // Erase is taken at any pulse length; the host times it, not us
    always @(posedge clk) begin
        wr_q <= wr;
        rd_q <= rd;
        if (wr && !wr_q) a_q <= addr;
        if (!wr && wr_q && busy == 0 && !PROTECT && hv) begin
            foreach (mem[i]) mem[i] <= 8'hFF;
        end else if (!wr && wr_q && busy == 0 && !PROTECT) begin
            pg[a_q[5:0]] <= dq_in;
            pg_v[a_q[5:0]] <= 1'h1;
            last_a <= a_q;
            last_d <= dq_in;
            win <= WIN_LEN;
        end else if (win > 0) begin
            win <= win - 1;
            if (win == 1) busy <= PROG_LEN;
        end
        if (busy > 0) begin
            busy <= busy - 1;
            if (rd_q && !rd) tog <= !tog;
            if (busy == 1) begin
                for (int i = 0; i < 64; i++) begin
                    if (pg_v[i]) mem[{last_a[10:6], i[5:0]}] <= pg[i];
                end
                pg_v <= 64'h0;
                tog <= 1'h0;
            end
        end
    end
    // Status replaces data only while programming runs
    always_comb begin
        dq_q = mem[addr];
        dq_en = rd ? 8'hFF : 8'h00;
        if (busy > 0) begin
            dq_q = {~last_d[7], tog, 1'h1, 5'h00};
            dq_en = rd ? 8'hE0 : 8'h00;
        end
    end
    assign rb_low = busy > 0;
endmodule // pee_dev_model
`default_nettype wire

/* File: tb/parallel_eeprom_write_status_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module parallel_eeprom_write_status_bench import pee_pkg::*; ;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_arvalid = 1'h0;
    logic s_bready = 1'h1, s_rready = 1'h1;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ready_busy_n;
    logic [1:0] s_bresp, s_rresp, r;
    logic [31:0] s_rdata, st;
    logic [10:0] address_pins;
    logic [7:0] data_out, data_pins, dev_q, dev_en;
    logic [7:0] last_v = 8'h00;
    logic data_oe_n, ce_n, oe_n, we_n, erase_hv_en, rb_low;
    int error_cnt = 0;
    int total_checks = 0;
    logic [10:0] ra [5] = '{11'h123, 11'h140, 11'h17F, 11'h180, 11'h200};
    logic [7:0] rv [5] = '{8'h5A, 8'h11, 8'hEE, 8'hFF, 8'hFF};
    always #10 clk = !clk;
    pee_ctrl #(.PROG_TMO(200), .ERASE_LEN(20), .LOAD_WIN(50)) uut (
        .clk(clk), .rst_n(rst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .address_pins(address_pins), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_pins(data_pins), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .erase_hv_en(erase_hv_en), .ready_busy_n(ready_busy_n));
    pee_dev_model dev (.clk(clk), .addr(address_pins), .dq_in(data_pins), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .hv(erase_hv_en), .dq_q(dev_q), .dq_en(dev_en),
        .rb_low(rb_low));
    // ------
    // Wire resolution
    // ------
    // Undriven bits show the inverse of last cycle, so a float never reads as a value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            data_pins[i] = !data_oe_n ? data_out[i] : dev_en[i] ? dev_q[i] : ~last_v[i];
        end
    end
    // Cleared in reset so an unknown from before reset cannot keep circulating
    always @(posedge clk) last_v <= rst_n ? data_pins : 8'h00;
    assign ready_busy_n = rb_low ? 1'h0 : 1'h1; // Pull-up when released
    // ------
    // Bus tasks
    // ------
    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Ready and response channels are kept open; valids drop when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        logic aw, w, got;
        aw = 1'h0;
        w = 1'h0;
        got = 1'h0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        while (!got) begin
            @(posedge clk);
            if (aw && w && s_bvalid) begin
                rs = s_bresp;
                got = 1'h1;
            end
            if (!aw && s_awready) begin
                aw = 1'h1;
                s_awvalid <= 1'h0;
            end
            if (!w && s_wready) begin
                w = 1'h1;
                s_wvalid <= 1'h0;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic t, got;
        t = 1'h0;
        got = 1'h0;
        s_araddr <= a;
        s_arvalid <= 1'h1;
        while (!got) begin
            @(posedge clk);
            if (t && s_rvalid) begin
                d = s_rdata;
                rs = s_rresp;
                got = 1'h1;
            end
            if (!t && s_arready) begin
                t = 1'h1;
                s_arvalid <= 1'h0;
            end
        end
    endtask
    // Launch one operation and wait until the sequencer settles
    task automatic cmd(input logic [1:0] op, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        axi_wr(REG_CMD, {5'h00, a, d, 6'h00, op}, r);
        do begin
            axi_rd(REG_STAT, st, r);
            n++;
        end while ((st[STAT_BUSY] || !(st[STAT_DONE] || st[STAT_ERR])) && n < 200);
        // A poll limit that runs out is counted as a mismatch
        check("settled", {st[STAT_BUSY], st[STAT_DONE] | st[STAT_ERR]}, 2'h1);
    endtask
    task automatic wait_rb(input logic v);
        int n;
        n = 0;
        do begin
            axi_rd(REG_STAT, st, r);
            n++;
        end while (st[STAT_RB] !== v && n < 300);
        check("ready/busy wait", st[STAT_RB], v);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ------
    // Tests
    // ------
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        check("idle pins", {ce_n, oe_n, we_n, data_oe_n, erase_hv_en}, 5'h1E);
        axi_rd(8'h0C, st, r);
        check("unmapped", {r, st}, {RESP_SLVERR, 32'h0});
        cmd(OP_WRITE, 11'h123, 8'h5A);
        check("byte write", st[2:0], 3'h2);
        wait_rb(1'h0);
        check("busy pin", st[STAT_RB], 1'h0);
        cmd(OP_WRITE, 11'h200, 8'h33);
        check("write while busy", st[STAT_ERR], 1'h1);
        cmd(OP_READ, 11'h123, 8'h00);
        check("status first", st[15:13], 3'h5);
        check("timer bit", st[STAT_PLT], 1'h1);
        cmd(OP_READ, 11'h123, 8'h00);
        check("status second", st[14], 1'h1);
        cmd(OP_POLL, 11'h123, 8'h00);
        check("poll end", {st[STAT_RB], st[STAT_TMO], st[STAT_DONE]}, 3'h5);
        // Page load with the cross-page guard on
        axi_wr(REG_CTRL, 32'h1, r);
        check("ctrl resp", r, RESP_OKAY);
        cmd(OP_WRITE, 11'h140, 8'h11);
        check("window open", st[STAT_WIN], 1'h1);
        cmd(OP_WRITE, 11'h17F, 8'hEE);
        cmd(OP_WRITE, 11'h180, 8'h77);
        check("cross page", st[STAT_ERR], 1'h1);
        wait_rb(1'h0);
        cmd(OP_POLL, 11'h17F, 8'h00);
        check("page poll", st[STAT_DONE], 1'h1);
        for (int i = 0; i < 5; i++) begin
            cmd(OP_READ, ra[i], 8'h00);
            check("read back", st[15:8], rv[i]);
        end
        cmd(OP_ERASE, 11'h000, 8'h00);
        cmd(OP_READ, 11'h123, 8'h00);
        check("erased", st[15:8], 8'hFF);
        complete_run();
    end
endmodule // parallel_eeprom_write_status_bench
`default_nettype wire
